/* File: verilog/tic_params.svh */
/*
 * Constants of the timer input-capture conditioning stage: register
 * offsets, field positions, reset values and divider settings.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define TIC_ADDR_W      8
`define TIC_OFS_CTL01   8'h18
`define TIC_OFS_CTL23   8'h1c
`define TIC_OFS_CHEN    8'h20
`define TIC_OFS_STAT    8'h24

// ----------------------------------------------------------------
// Field layout within one channel byte
// ----------------------------------------------------------------
`define TIC_NCH         4
`define TIC_MS_LSB      0
`define TIC_PSC_LSB     2
`define TIC_FLT_LSB     4
`define TIC_HI_CH_LSB   8

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define TIC_CTL_RST     8'h00
`define TIC_CHEN_RST    4'h0
`define TIC_DTS_DIV     1
`define TIC_DIV_W       5

`endif

/* File: verilog/tic_pkg.sv */
/*
 * Types of the timer input-capture conditioning stage.
 * Assumes tic_params.svh is on the include path.
 */
`include "tic_params.svh"

package tic_pkg;

   // ----------------------------------------------------------------
   // Channel direction and capture source
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TIC_MS_OUT   = 2'h0,
      TIC_MS_OWN   = 2'h1,
      TIC_MS_NEIGH = 2'h2,
      TIC_MS_TRIG  = 2'h3
   } tic_mode_e;

   // ----------------------------------------------------------------
   // Carriers and state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`TIC_ADDR_W-1:0] addr;
      logic [31:0]            wdata;
      logic                   wr;
      logic                   rd;
   } tic_bus_req_s;

   typedef struct packed {
      logic       lvl;
      logic [2:0] cnt;
   } tic_filt_state_s;

   typedef struct packed {
      logic [`TIC_NCH-1:0][7:0] ctl;
      logic [`TIC_NCH-1:0]      chanEn;
      logic [`TIC_NCH-1:0]      sync1;
      logic [`TIC_NCH-1:0]      sync2;
      logic [`TIC_NCH-1:0]      sync3;
      logic [`TIC_NCH-1:0]      rawLvl;
      logic [7:0]               dtsCnt;
      logic [`TIC_DIV_W-1:0]    divCnt;
      logic [5:0]               tick;
      logic [`TIC_NCH-1:0][2:0] pscCnt;
      logic [`TIC_NCH-1:0]      prevSrc;
      logic [`TIC_NCH-1:0]      filtLvl;
      logic [`TIC_NCH-1:0]      capture;
      logic [31:0]              rdata;
   } tic_top_state_s;

endpackage : tic_pkg

/* File: verilog/tic_glitch_filter.sv */
/*
 * One channel's digital glitch filter.
 * Assumes a synchronised sample and one-cycle tick pulses, index 0
 * being every kernel clock, 1..5 the dead-time base divided by 2..32.
 */
`timescale 1ns/10ps
`include "tic_params.svh"

module tic_glitch_filter
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstN,
   // Sample and setting
   input  wire logic       sample,
   input  wire logic [3:0] filtSel,
   input  wire logic [5:0] ticks,
   // Filtered level
   output logic            filtLevel
);

   tic_pkg::tic_filt_state_s st_reg;
   tic_pkg::tic_filt_state_s st_next;
   logic [2:0]               needM1;
   logic                     tickSel;

   // ----------------------------------------------------------------
   // Sample count and rate per setting
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (filtSel)
         4'h1:                      needM1 = 3'h1;
         4'h2:                      needM1 = 3'h3;
         4'h4, 4'h6, 4'h8:          needM1 = 3'h5;
         4'ha, 4'hd:                needM1 = 3'h4;
         4'hb, 4'he:                needM1 = 3'h5;
         default:                   needM1 = 3'h7;
      endcase
      unique case (filtSel)
         4'h4, 4'h5:                tickSel = ticks[1];
         4'h6, 4'h7:                tickSel = ticks[2];
         4'h8, 4'h9:                tickSel = ticks[3];
         4'ha, 4'hb, 4'hc:          tickSel = ticks[4];
         4'hd, 4'he, 4'hf:          tickSel = ticks[5];
         default:                   tickSel = ticks[0];
      endcase
   end

   // ----------------------------------------------------------------
   // Counting of consecutive samples at the new level
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      if (filtSel == 4'h0)
      begin
         st_next.lvl = sample;
         st_next.cnt = 3'h0;
      end
      else if (tickSel)
      begin
         if (sample == st_reg.lvl)
            st_next.cnt = 3'h0;
         // A count left above a lowered limit by a setting change
         // qualifies at once rather than wrapping round
         else if (st_reg.cnt >= needM1)
         begin
            st_next.lvl = sample;
            st_next.cnt = 3'h0;
         end
         else
            st_next.cnt = st_reg.cnt + 3'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign filtLevel = st_reg.lvl;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstN);

   property p_bypass;
      filtSel == 4'h0 |=> filtLevel == $past(sample);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("Unfiltered channel did not follow its input");

   property p_qualified;
      ($past(filtSel) != 4'h0) && $changed(filtLevel)
         |-> $past(st_reg.cnt) >= $past(needM1);
   endproperty
   a_qualified: assert property (p_qualified)
      else $error("Filter level changed before the sample count");

   property p_fast2;
      (filtSel == 4'h1) && (sample != filtLevel) ##1
      (filtSel == 4'h1) && (sample == $past(sample))
         |=> filtLevel == $past(sample);
   endproperty
   a_fast2: assert property (p_fast2)
      else $error("Two equal samples did not qualify a level");

   property p_hold;
      (filtSel != 4'h0) && !tickSel |=> $stable(filtLevel);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Filter level moved without a sampling tick");

   c_change: cover property (filtSel != 4'h0 ##1 $changed(filtLevel));

endmodule : tic_glitch_filter

/* File: verilog/tic_capture_cond.sv */
/*
 * Input-capture conditioning stage of a four-channel timer: glitch
 * filters, capture source selection, edge prescalers and their
 * control registers on a simple strobe port.
 * Assumes the channel inputs are asynchronous pins, the internal
 * trigger comes from logic on core_clk, and the capture path that
 * consumes captureEvent is outside this block.
 */
`timescale 1ns/10ps
`include "tic_params.svh"

module tic_capture_cond
#(
   parameter int DTS_DIV = `TIC_DTS_DIV
)
(
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   // Register port
   input  wire logic [`TIC_ADDR_W-1:0] regAddr,
   input  wire logic [31:0]            regWdata,
   input  wire logic                   regWr,
   input  wire logic                   regRd,
   output logic [31:0]                 regRdata,
   // Channel inputs
   input  wire logic [`TIC_NCH-1:0]    channelRawInput,
   input  wire logic                   internalTrigger,
   // Conditioned outputs
   output logic [`TIC_NCH-1:0]         filteredLevel,
   output logic [`TIC_NCH-1:0]         captureEvent
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   generate
      if (DTS_DIV < 1 || DTS_DIV > 256)
      begin : g_bad_div
         $error("DTS_DIV must lie between 1 and 256");
      end
   endgenerate

   localparam logic [7:0] DtsLast = 8'(DTS_DIV - 1);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rstSync_reg;
   logic       rstN;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         rstSync_reg <= 2'h0;
      else
         rstSync_reg <= {rstSync_reg[0], 1'b1};
   end

   assign rstN = rstSync_reg[1];

   // ----------------------------------------------------------------
   // State and helpers
   // ----------------------------------------------------------------
   tic_pkg::tic_top_state_s  st_reg;
   tic_pkg::tic_top_state_s  st_next;
   tic_pkg::tic_bus_req_s    bus;
   tic_pkg::tic_mode_e       mode [`TIC_NCH];
   logic [`TIC_NCH-1:0]      filtOut;
   logic [`TIC_NCH-1:0]      srcLvl;
   logic [`TIC_NCH-1:0]      srcEdge;
   logic [`TIC_NCH-1:0][2:0] pscLast;
   logic                     wrCtl01;
   logic                     wrCtl23;

   assign bus.addr  = regAddr;
   assign bus.wdata = regWdata;
   assign bus.wr    = regWr;
   assign bus.rd    = regRd;
   assign wrCtl01   = bus.wr && (bus.addr == `TIC_OFS_CTL01);
   assign wrCtl23   = bus.wr && (bus.addr == `TIC_OFS_CTL23);

   // ----------------------------------------------------------------
   // Per-channel filter, source select and prescaler limit
   // ----------------------------------------------------------------
   generate
      for (genvar i = 0; i < `TIC_NCH; i++)
      begin : g_ch
         tic_glitch_filter u_filt
         (
            .core_clk  (core_clk),
            .rstN      (rstN),
            .sample    (st_reg.rawLvl[i]),
            .filtSel   (st_reg.ctl[i][`TIC_FLT_LSB+:4]),
            .ticks     (st_reg.tick),
            .filtLevel (filtOut[i])
         );

         always_comb
         begin
            mode[i] = tic_pkg::tic_mode_e'(st_reg.ctl[i][`TIC_MS_LSB+:2]);
            unique case (mode[i])
               tic_pkg::TIC_MS_OWN:   srcLvl[i] = filtOut[i];
               tic_pkg::TIC_MS_NEIGH: srcLvl[i] = filtOut[i^1];
               tic_pkg::TIC_MS_TRIG:  srcLvl[i] = internalTrigger;
               tic_pkg::TIC_MS_OUT:   srcLvl[i] = 1'b0;
            endcase
            unique case (st_reg.ctl[i][`TIC_PSC_LSB+:2])
               2'h0: pscLast[i] = 3'h0;
               2'h1: pscLast[i] = 3'h1;
               2'h2: pscLast[i] = 3'h3;
               2'h3: pscLast[i] = 3'h7;
            endcase
         end

         assign srcEdge[i] = srcLvl[i] && !st_reg.prevSrc[i];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;

      // Three-stage capture of the pins; a level counts once the
      // last two stages agree, so one metastable sample never does
      st_next.sync1 = channelRawInput;
      st_next.sync2 = st_reg.sync1;
      st_next.sync3 = st_reg.sync2;
      for (int i = 0; i < `TIC_NCH; i++)
      begin
         if (st_reg.sync2[i] == st_reg.sync3[i])
            st_next.rawLvl[i] = st_reg.sync3[i];
      end

      // Dead-time base tick and its binary divisions
      st_next.tick = 6'h01;
      if (st_reg.dtsCnt == DtsLast)
      begin
         st_next.dtsCnt = 8'h00;
         st_next.divCnt = st_reg.divCnt + 5'h01;
         st_next.tick[1] = st_reg.divCnt[0];
         st_next.tick[2] = &st_reg.divCnt[1:0];
         st_next.tick[3] = &st_reg.divCnt[2:0];
         st_next.tick[4] = &st_reg.divCnt[3:0];
         st_next.tick[5] = &st_reg.divCnt[4:0];
      end
      else
         st_next.dtsCnt = st_reg.dtsCnt + 8'h01;

      // Register writes; upper halves are reserved and dropped
      if (wrCtl01)
      begin
         for (int i = 0; i < 2; i++)
         begin
            st_next.ctl[i][7:2] = bus.wdata[8*i+2+:6];
            if (!st_reg.chanEn[i])
               st_next.ctl[i][1:0] = bus.wdata[8*i+:2];
         end
      end
      if (wrCtl23)
      begin
         for (int i = 2; i < 4; i++)
         begin
            st_next.ctl[i][7:2] = bus.wdata[8*(i-2)+2+:6];
            if (!st_reg.chanEn[i])
               st_next.ctl[i][1:0] = bus.wdata[8*(i-2)+:2];
         end
      end
      if (bus.wr && (bus.addr == `TIC_OFS_CHEN))
         st_next.chanEn = bus.wdata[`TIC_NCH-1:0];

      // Edge prescalers; a disabled channel restarts from zero
      st_next.prevSrc = srcLvl;
      st_next.filtLvl = filtOut;
      st_next.capture = '0;
      for (int i = 0; i < `TIC_NCH; i++)
      begin
         if (!st_reg.chanEn[i])
            st_next.pscCnt[i] = 3'h0;
         else if (srcEdge[i] && (mode[i] != tic_pkg::TIC_MS_OUT))
         begin
            // At or above the limit, so a lowered ratio never wraps
            if (st_reg.pscCnt[i] >= pscLast[i])
            begin
               st_next.pscCnt[i]  = 3'h0;
               st_next.capture[i] = 1'b1;
            end
            else
               st_next.pscCnt[i] = st_reg.pscCnt[i] + 3'h1;
         end
      end

      // Read data stand for the cycle after the strobe only
      st_next.rdata = 32'h0;
      if (bus.rd)
      begin
         unique case (bus.addr)
            `TIC_OFS_CTL01: st_next.rdata = {16'h0, st_reg.ctl[1],
                                             st_reg.ctl[0]};
            `TIC_OFS_CTL23: st_next.rdata = {16'h0, st_reg.ctl[3],
                                             st_reg.ctl[2]};
            `TIC_OFS_CHEN:  st_next.rdata = {28'h0, st_reg.chanEn};
            `TIC_OFS_STAT:  st_next.rdata = {28'h0, st_reg.filtLvl};
            default:        st_next.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         st_reg        <= '0;
         st_reg.ctl    <= {`TIC_NCH{`TIC_CTL_RST}};
         st_reg.chanEn <= `TIC_CHEN_RST;
      end
      else
         st_reg <= st_next;
   end

   assign regRdata      = st_reg.rdata;
   assign filteredLevel = st_reg.filtLvl;
   assign captureEvent  = st_reg.capture;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstN);

   property p_readCtl23;
      regRd && (regAddr == `TIC_OFS_CTL23)
         |=> regRdata == {16'h0, $past(st_reg.ctl[3]),
                          $past(st_reg.ctl[2])};
   endproperty
   a_readCtl23: assert property (p_readCtl23)
      else $error("Second control word read back wrong");

   property p_modeLocked;
      wrCtl01 && st_reg.chanEn[0]
         |=> $stable(st_reg.ctl[0][1:0]);
   endproperty
   a_modeLocked: assert property (p_modeLocked)
      else $error("Mode field changed while channel enabled");

   property p_modeField;
      wrCtl01 && !st_reg.chanEn[1]
         |=> st_reg.ctl[1][1:0] == $past(regWdata[9:8]);
   endproperty
   a_modeField: assert property (p_modeField)
      else $error("Channel 1 mode not taken from bits 9:8");

   property p_filtField;
      wrCtl01 |=> st_reg.ctl[1][7:4] == $past(regWdata[15:12]);
   endproperty
   a_filtField: assert property (p_filtField)
      else $error("Channel 1 filter not taken from bits 15:12");

   property p_pscField;
      wrCtl01 |=> st_reg.ctl[0][3:2] == $past(regWdata[3:2]);
   endproperty
   a_pscField: assert property (p_pscField)
      else $error("Channel 0 prescaler not taken from bits 3:2");

   property p_pscClear;
      !st_reg.chanEn[0] |=> st_reg.pscCnt[0] == 3'h0;
   endproperty
   a_pscClear: assert property (p_pscClear)
      else $error("Prescaler count kept while channel disabled");

   property p_everyEdge;
      st_reg.chanEn[0] && srcEdge[0] && (mode[0] != tic_pkg::TIC_MS_OUT)
         && (st_reg.ctl[0][3:2] == 2'h0) |=> captureEvent[0];
   endproperty
   a_everyEdge: assert property (p_everyEdge)
      else $error("Undivided prescaler missed a capture");

   property p_outputNoCap;
      mode[1] == tic_pkg::TIC_MS_OUT |=> !captureEvent[1];
   endproperty
   a_outputNoCap: assert property (p_outputNoCap)
      else $error("Output channel produced a capture");

   property p_divNest;
      st_reg.tick[4] |-> st_reg.tick[3] && st_reg.tick[2]
                         && st_reg.tick[1] && st_reg.tick[0];
   endproperty
   a_divNest: assert property (p_divNest)
      else $error("Divided sampling ticks out of step");

   property p_upperZero;
      regRd ##1 1'b1 |-> regRdata[31:16] == 16'h0;
   endproperty
   a_upperZero: assert property (p_upperZero)
      else $error("Reserved upper half read nonzero");

   property p_filtCh0;
      wrCtl01 |=> st_reg.ctl[0][7:4] == $past(regWdata[7:4]);
   endproperty
   a_filtCh0: assert property (p_filtCh0)
      else $error("Channel 0 filter not taken from bits 7:4");

   property p_pscCh1;
      wrCtl01 |=> st_reg.ctl[1][3:2] == $past(regWdata[11:10]);
   endproperty
   a_pscCh1: assert property (p_pscCh1)
      else $error("Channel 1 prescaler not taken from bits 11:10");

   property p_filtCh3;
      wrCtl23 |=> st_reg.ctl[3][7:4] == $past(regWdata[15:12]);
   endproperty
   a_filtCh3: assert property (p_filtCh3)
      else $error("Channel 3 filter not taken from bits 15:12");

   property p_neighCap;
      st_reg.chanEn[1] && (mode[1] == tic_pkg::TIC_MS_NEIGH)
         && (st_reg.ctl[1][3:2] == 2'h0) && filtOut[0]
         && !st_reg.prevSrc[1] |=> captureEvent[1];
   endproperty
   a_neighCap: assert property (p_neighCap)
      else $error("Neighbour channel edge missed a capture");

   c_capture:  cover property (captureEvent[0]);
   c_div8:     cover property (st_reg.ctl[1][3:2] == 2'h3
                               ##1 captureEvent[1]);
   c_locked:   cover property (wrCtl23 && st_reg.chanEn[3]);

endmodule : tic_capture_cond

/* File: tb/tic_pin_source.sv */
/*
 * Model of the external sources that drive the four channel pins.
 * Assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/10ps

module tic_pin_source
(
   // Clock
   input  wire logic core_clk,
   // Pins toward the channel inputs
   output logic [3:0] channelRawInput
);
   // Push-pull source: the pins always carry a defined level
   initial channelRawInput = 4'h0;

   task automatic setPin(input int ch, input logic lvl);
      @(posedge core_clk);
      channelRawInput[ch] <= lvl;
   endtask : setPin

   // Excursion of w kernel cycles, then back to the opposite level
   task automatic pulse(input int ch, input logic lvl, input int w);
      setPin(ch, lvl);
      repeat (w) @(posedge core_clk);
      channelRawInput[ch] <= ~lvl;
   endtask : pulse
endmodule : tic_pin_source

/* File: tb/tb_timer_input_capture_conditioning.sv */
/*
 * Self-checking bench of the input-capture conditioning stage.
 * Assumes DTS_DIV of 1, so each divided tick is a power of two cycles.
 */
`timescale 1ns/10ps
`include "tic_params.svh"

module tb_timer_input_capture_conditioning;
   logic        core_clk;
   logic        rst_b;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdata;
   logic        internalTrigger;
   logic [3:0]  channelRawInput;
   logic [3:0]  filteredLevel;
   logic [3:0]  captureEvent;
   logic [31:0] rdVal;
   logic [31:0] seed = 32'hab83;
   logic [7:0]  ctl [4];
   int          miscompares;
   int          tests_run;
   int          capCnt [4];
   int          srcExp [4] = '{0, 5, 2, 3};
   logic [7:0]  rdAddr [5] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};

   tic_capture_cond #(.DTS_DIV(1)) u_dut (.core_clk(core_clk),
      .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .channelRawInput(channelRawInput),
      .internalTrigger(internalTrigger),
      .filteredLevel(filteredLevel), .captureEvent(captureEvent));

   tic_pin_source u_src (.core_clk(core_clk),
      .channelRawInput(channelRawInput));

   always #2.5 core_clk = ~core_clk;

   always @(posedge core_clk)
      for (int i = 0; i < 4; i++)
         if (captureEvent[i] === 1'b1)
            capCnt[i]++;

   // ----------------------------------------------------------------
   // Expectation helpers
   // ----------------------------------------------------------------
   function automatic int rnd(input int lo, input int hi);
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      rnd = lo + int'(seed[7:0]) % (hi - lo + 1);
   endfunction : rnd

   function automatic int fltN(input int c);
      case (c)
         0: fltN = 1;
         1: fltN = 2;
         2: fltN = 4;
         4, 6, 8: fltN = 6;
         10, 13: fltN = 5;
         11, 14: fltN = 6;
         default: fltN = 8;
      endcase
   endfunction : fltN

   function automatic int fltP(input int c);
      fltP = (c < 4) ? 1 : (c < 10) ? (2 << ((c - 4) / 2)) :
             (c < 13) ? 16 : 32;
   endfunction : fltP

   // ----------------------------------------------------------------
   // Checks and bus cycles
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h",
                  $time, got, exp);
      end
   endtask : chk

   task automatic chkRange(input int k, input int lo, input int hi);
      chk(32'(k), (k >= lo && k <= hi) ? 32'(k) : 32'(lo));
   endtask : chkRange

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge core_clk);
      regWr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge core_clk);
      regRd   <= 1'b0;
      #1;
      rdVal = regRdata;
   endtask : rd

   // Control words hold two channel bytes, so both are rewritten
   task automatic cfg(input int ch, input logic [7:0] b);
      ctl[ch] = b;
      wr((ch < 2) ? 8'h18 : 8'h1c, {16'h0, ctl[(ch & 2) + 1], ctl[ch & 2]});
   endtask : cfg

   task automatic waitLvl(input int ch, input logic lvl, output int n);
      n = 0;
      while (filteredLevel[ch] !== lvl && n < 2000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask : waitLvl

   task automatic edges(input int ch, input int k);
      repeat (k)
      begin
         u_src.pulse(ch, 1'b1, rnd(2, 5));
         repeat (rnd(3, 6)) @(posedge core_clk);
      end
   endtask : edges

   task results;
      $display("Counts: %0d compared, %0d miscompares", tests_run,
               miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Watchdog at 80k cycles; whole sequence needs well under 40k
   // ----------------------------------------------------------------
   initial
   begin
      #400000;
      miscompares++;
      results;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      int n, p, k, ch, base;
      logic [7:0] a;
      logic [31:0] d;
      core_clk = 1'b0;
      rst_b = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      internalTrigger = 1'b0;
      for (int i = 0; i < 4; i++)
         ctl[i] = 8'h00;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      foreach (rdAddr[i])
      begin
         rd(rdAddr[i]);
         chk(rdVal, 32'h0);
      end
      for (int i = 0; i < 3; i++)
      begin
         a = 8'h18 + 8'(4 * i);
         d = {16'h0, 8'(rnd(0, 255)), 8'(rnd(0, 255))};
         d = (i == 2) ? (d & 32'hf) : d;
         wr(a, d);
         rd(a);
         chk(rdVal, d);
      end
      wr(8'h24, 32'hf);
      rd(8'h24);
      chk(rdVal, 32'h0);
      $display("Test registers done");
      wr(8'h20, 32'h0);
      wr(8'h18, 32'h5);
      wr(8'h1c, 32'h100);
      wr(8'h20, 32'h9);
      wr(8'h18, 32'hf6);
      wr(8'h1c, 32'h200);
      rd(8'h18);
      chk(rdVal, 32'hf5);
      rd(8'h1c);
      chk(rdVal, 32'h100);
      wr(8'h20, 32'h0);
      wr(8'h18, 32'hf6);
      rd(8'h18);
      chk(rdVal, 32'hf6);
      wr(8'h1c, 32'h0);
      $display("Test mode lock done");
      for (int c = 0; c < 16; c++)
      begin
         ch = c % 4;
         n = fltN(c);
         p = fltP(c);
         cfg(ch, {4'(c), 4'h1});
         repeat (2 * p + 4) @(posedge core_clk);
         if (c != 0)
         begin
            u_src.pulse(ch, 1'b1, (n - 1) * p);
            repeat (n * p + p + 10) @(posedge core_clk);
            chk(32'(filteredLevel[ch]), 32'h0);
         end
         u_src.setPin(ch, 1'b1);
         waitLvl(ch, 1'b1, k);
         chkRange(k, (n - 1) * p + 2, n * p + p + 8);
         rd(8'h24);
         chk(rdVal, 32'(1 << ch));
         if (c != 0)
         begin
            u_src.pulse(ch, 1'b0, (n - 1) * p);
            repeat (n * p + p + 10) @(posedge core_clk);
            chk(32'(filteredLevel[ch]), 32'h1);
         end
         u_src.setPin(ch, 1'b0);
         waitLvl(ch, 1'b0, k);
         chkRange(k, (n - 1) * p + 2, n * p + p + 8);
      end
      $display("Test filter codes done");
      for (int q = 0; q < 4; q++)
      begin
         wr(8'h20, 32'h0);
         cfg(0, {4'h0, 2'(q), 2'b01});
         wr(8'h20, 32'h1);
         base = capCnt[0];
         edges(0, 16);
         repeat (12) @(posedge core_clk);
         chk(32'(capCnt[0] - base), 32'(16 >> q));
      end
      wr(8'h20, 32'h0);
      cfg(0, 8'h09);
      wr(8'h20, 32'h1);
      base = capCnt[0];
      edges(0, 3);
      wr(8'h20, 32'h0);
      wr(8'h20, 32'h1);
      edges(0, 1);
      repeat (12) @(posedge core_clk);
      chk(32'(capCnt[0] - base), 32'h0);
      edges(0, 3);
      repeat (12) @(posedge core_clk);
      chk(32'(capCnt[0] - base), 32'h1);
      $display("Test prescaler done");
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h20, 32'h0);
         cfg(1, {6'h0, 2'(m)});
         wr(8'h20, 32'h2);
         base = capCnt[1];
         edges(0, 2);
         repeat (3)
         begin
            @(posedge core_clk);
            internalTrigger <= 1'b1;
            repeat (2) @(posedge core_clk);
            internalTrigger <= 1'b0;
            repeat (3) @(posedge core_clk);
         end
         edges(1, 5);
         repeat (12) @(posedge core_clk);
         chk(32'(capCnt[1] - base), 32'(srcExp[m]));
      end
      $display("Test capture source done");
      results;
   end
endmodule : tb_timer_input_capture_conditioning
